// File: rlc_pkg.sv
// Package for the reference cleanup loop control register bank.
// Assumes an 8-bit register port with 16-bit addresses from the serial port.
package rlc_pkg;
  localparam logic [15:0] ADDR_TRANSFER = 16'h000f;
  localparam logic [15:0] ADDR_REF_A_DIV_LOW = 16'h0100;
  localparam logic [15:0] ADDR_REF_A_DIV_HIGH = 16'h0101;
  localparam logic [15:0] ADDR_REF_B_DIV_LOW = 16'h0102;
  localparam logic [15:0] ADDR_REF_B_DIV_HIGH = 16'h0103;
  localparam logic [15:0] ADDR_FB_DIV_LOW = 16'h0104;
  localparam logic [15:0] ADDR_FB_DIV_HIGH = 16'h0105;
  localparam logic [15:0] ADDR_PUMP_CURRENT = 16'h0106;
  localparam logic [15:0] ADDR_PUMP_MODE = 16'h0107;
  localparam logic [15:0] ADDR_RECEIVER = 16'h0108;
  localparam logic [15:0] ADDR_PIN_SELECT = 16'h0109;
  localparam int NUM_REGS = 10;
  // Bank index of each register, counted from the first divider byte
  localparam int IDX_REF_A_LOW = 0;
  localparam int IDX_REF_A_HIGH = 1;
  localparam int IDX_REF_B_LOW = 2;
  localparam int IDX_REF_B_HIGH = 3;
  localparam int IDX_FB_LOW = 4;
  localparam int IDX_FB_HIGH = 5;
  localparam int IDX_PUMP_CURRENT = 6;
  localparam int IDX_PUMP_MODE = 7;
  localparam int IDX_RECEIVER = 8;
  localparam int IDX_PIN_SELECT = 9;
  localparam int DIV_HIGH_WIDTH = 2;
  localparam int PUMP_CURRENT_WIDTH = 7;
  localparam int PUMP_MODE_WIDTH = 2;
  localparam int TRANSFER_BIT = 0;
  localparam int FORCE_HOLD_BIT = 7;
  localparam int AUTO_HOLD_OFF_BIT = 5;
  localparam int B_DIFF_BIT = 6;
  localparam int A_DIFF_BIT = 5;
  localparam int B_ENABLE_BIT = 4;
  localparam int A_ENABLE_BIT = 3;
  localparam int B_NEG_PIN_BIT = 1;
  localparam int A_NEG_PIN_BIT = 0;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [9:0] DIV_MIN = 10'h001;
  // Writable bits per register; the rest are reserved and read zero
  localparam logic [7:0] MASK_LOW = 8'hff;
  localparam logic [7:0] MASK_HIGH = 8'h03;
  localparam logic [7:0] MASK_PUMP_CURRENT = 8'hff;
  localparam logic [7:0] MASK_PUMP_MODE = 8'h23;
  localparam logic [7:0] MASK_RECEIVER = 8'h78;
  localparam logic [7:0] MASK_PIN_SELECT = 8'h03;
  typedef enum logic [1:0] {
    RLC_PUMP_TRISTATE = 2'h0,
    RLC_PUMP_DOWN = 2'h1,
    RLC_PUMP_UP = 2'h2,
    RLC_PUMP_NORMAL = 2'h3
  } rlc_pump_mode_t;
endpackage

// File: rlc_regs.sv
// Buffered register bank for the reference cleanup loop controls.
// Assumes a serial port front end giving one-cycle write/read strobes.
`timescale 1ns/1ps
module rlc_regs
  import rlc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [9:0] ref_a_divide,
  output logic [9:0] ref_b_divide,
  output logic [9:0] feedback_divide,
  output logic [6:0] pump_current,
  output logic pump_up_enable,
  output logic pump_down_enable,
  output logic pump_tristate,
  output logic auto_hold_enable,
  output logic ref_a_rx_enable,
  output logic ref_a_differential,
  output logic ref_a_pos_pin_enable,
  output logic ref_a_neg_pin_enable,
  output logic ref_b_rx_enable,
  output logic ref_b_differential,
  output logic ref_b_pos_pin_enable,
  output logic ref_b_neg_pin_enable
);

  logic [7:0] buffer_regs [NUM_REGS];
  logic [7:0] active_regs [NUM_REGS];
  logic transfer;

  function automatic int reg_index(input logic [15:0] a);
    int idx;
    idx = -1;
    if (a >= ADDR_REF_A_DIV_LOW && a <= ADDR_PIN_SELECT) begin
      idx = int'(a - ADDR_REF_A_DIV_LOW);
    end
    return idx;
  endfunction

  function automatic logic [7:0] reg_mask(input int idx);
    logic [7:0] m;
    m = 8'h00;
    case (idx)
      IDX_REF_A_LOW, IDX_REF_B_LOW, IDX_FB_LOW: m = MASK_LOW;
      IDX_REF_A_HIGH, IDX_REF_B_HIGH, IDX_FB_HIGH: m = MASK_HIGH;
      IDX_PUMP_CURRENT: m = MASK_PUMP_CURRENT;
      IDX_PUMP_MODE: m = MASK_PUMP_MODE;
      IDX_RECEIVER: m = MASK_RECEIVER;
      IDX_PIN_SELECT: m = MASK_PIN_SELECT;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Divider hardware treats zero as one, so clamp here
  function automatic logic [9:0] div_ratio(input logic [7:0] lo, input logic [7:0] hi);
    logic [9:0] v;
    v = {hi[DIV_HIGH_WIDTH-1:0], lo};
    if (v < DIV_MIN) begin
      v = DIV_MIN;
    end
    return v;
  endfunction

  // Strobe is self-clearing: it is never stored, so it reads zero
  assign transfer = wr_en && (addr == ADDR_TRANSFER) && wr_data[TRANSFER_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge clk) begin
        if (rst) begin
          buffer_regs[gi] <= RESET_VALUE;
        end else if (wr_en && reg_index(addr) == gi) begin
          buffer_regs[gi] <= wr_data & reg_mask(gi);
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          active_regs[gi] <= RESET_VALUE;
        end else if (transfer) begin
          active_regs[gi] <= buffer_regs[gi];
        end
      end
    end
  endgenerate

  // Reads return the buffer so software sees what it wrote before transfer
  logic [7:0] next_rd_data;
  always_comb begin
    next_rd_data = RESET_VALUE;
    if (rd_en && reg_index(addr) >= 0) begin
      next_rd_data = buffer_regs[reg_index(addr)];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
    end
  end

  // Unmapped and idle cycles read zero, so a stale byte never lingers
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= RESET_VALUE;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  logic [9:0] next_ref_a_divide;
  logic [9:0] next_ref_b_divide;
  logic [9:0] next_feedback_divide;
  assign next_ref_a_divide = div_ratio(active_regs[IDX_REF_A_LOW], active_regs[IDX_REF_A_HIGH]);
  assign next_ref_b_divide = div_ratio(active_regs[IDX_REF_B_LOW], active_regs[IDX_REF_B_HIGH]);
  assign next_feedback_divide = div_ratio(active_regs[IDX_FB_LOW], active_regs[IDX_FB_HIGH]);

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_a_divide <= DIV_MIN;
    end else begin
      ref_a_divide <= next_ref_a_divide;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_b_divide <= DIV_MIN;
    end else begin
      ref_b_divide <= next_ref_b_divide;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      feedback_divide <= DIV_MIN;
    end else begin
      feedback_divide <= next_feedback_divide;
    end
  end

  logic force_hold;
  rlc_pump_mode_t mode;
  logic next_pump_tristate;
  logic next_pump_up;
  logic next_pump_down;
  assign force_hold = active_regs[IDX_PUMP_CURRENT][FORCE_HOLD_BIT];
  assign mode = rlc_pump_mode_t'(active_regs[IDX_PUMP_MODE][PUMP_MODE_WIDTH-1:0]);

  // Forced holdover overrides every pump mode
  always_comb begin
    next_pump_tristate = 1'b1;
    next_pump_up = 1'b0;
    next_pump_down = 1'b0;
    if (force_hold) begin
      next_pump_tristate = 1'b1;
      next_pump_up = 1'b0;
      next_pump_down = 1'b0;
    end else begin
      case (mode)
        RLC_PUMP_TRISTATE: begin
          next_pump_tristate = 1'b1;
          next_pump_up = 1'b0;
          next_pump_down = 1'b0;
        end
        RLC_PUMP_DOWN: begin
          next_pump_tristate = 1'b0;
          next_pump_up = 1'b0;
          next_pump_down = 1'b1;
        end
        RLC_PUMP_UP: begin
          next_pump_tristate = 1'b0;
          next_pump_up = 1'b1;
          next_pump_down = 1'b0;
        end
        // Normal mode lets the phase detector drive both switches
        default: begin
          next_pump_tristate = 1'b0;
          next_pump_up = 1'b1;
          next_pump_down = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pump_current <= 7'h00;
    end else begin
      pump_current <= active_regs[IDX_PUMP_CURRENT][PUMP_CURRENT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_hold_enable <= 1'b1;
    end else begin
      auto_hold_enable <= !active_regs[IDX_PUMP_MODE][AUTO_HOLD_OFF_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pump_tristate <= 1'b1;
    end else begin
      pump_tristate <= next_pump_tristate;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pump_up_enable <= 1'b0;
    end else begin
      pump_up_enable <= next_pump_up;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pump_down_enable <= 1'b0;
    end else begin
      pump_down_enable <= next_pump_down;
    end
  end

  // Differential mode needs both pins; a powered-down receiver gets neither
  function automatic logic pin_enable(input logic en, input logic diff, input logic neg, input logic want_neg);
    return en && (diff || (neg == want_neg));
  endfunction

  logic a_en;
  logic b_en;
  logic a_diff;
  logic b_diff;
  logic a_neg;
  logic b_neg;
  assign a_en = active_regs[IDX_RECEIVER][A_ENABLE_BIT];
  assign b_en = active_regs[IDX_RECEIVER][B_ENABLE_BIT];
  assign a_diff = active_regs[IDX_RECEIVER][A_DIFF_BIT];
  assign b_diff = active_regs[IDX_RECEIVER][B_DIFF_BIT];
  assign a_neg = active_regs[IDX_PIN_SELECT][A_NEG_PIN_BIT];
  assign b_neg = active_regs[IDX_PIN_SELECT][B_NEG_PIN_BIT];

  logic next_a_pos;
  logic next_a_neg;
  logic next_b_pos;
  logic next_b_neg;
  assign next_a_pos = pin_enable(a_en, a_diff, a_neg, 1'b0);
  assign next_a_neg = pin_enable(a_en, a_diff, a_neg, 1'b1);
  assign next_b_pos = pin_enable(b_en, b_diff, b_neg, 1'b0);
  assign next_b_neg = pin_enable(b_en, b_diff, b_neg, 1'b1);

  // Powered-down receivers keep both pins off to save current
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_a_rx_enable <= 1'b0;
    end else begin
      ref_a_rx_enable <= a_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_a_differential <= 1'b0;
    end else begin
      ref_a_differential <= a_diff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_a_pos_pin_enable <= 1'b0;
    end else begin
      ref_a_pos_pin_enable <= next_a_pos;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_a_neg_pin_enable <= 1'b0;
    end else begin
      ref_a_neg_pin_enable <= next_a_neg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_b_rx_enable <= 1'b0;
    end else begin
      ref_b_rx_enable <= b_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_b_differential <= 1'b0;
    end else begin
      ref_b_differential <= b_diff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_b_pos_pin_enable <= 1'b0;
    end else begin
      ref_b_pos_pin_enable <= next_b_pos;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_b_neg_pin_enable <= 1'b0;
    end else begin
      ref_b_neg_pin_enable <= next_b_neg;
    end
  end

endmodule

// File: rlc_regs_sva.sv
// Checker for the cleanup loop register bank.
// Assumes it is bound to rlc_regs and sees only its ports.
`timescale 1ns/1ps
module rlc_regs_chk
  import rlc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [9:0] ref_a_divide,
  input wire logic [9:0] ref_b_divide,
  input wire logic [9:0] feedback_divide,
  input wire logic [6:0] pump_current,
  input wire logic pump_up_enable,
  input wire logic pump_down_enable,
  input wire logic pump_tristate,
  input wire logic auto_hold_enable,
  input wire logic ref_a_rx_enable,
  input wire logic ref_a_differential,
  input wire logic ref_a_pos_pin_enable,
  input wire logic ref_a_neg_pin_enable,
  input wire logic ref_b_rx_enable,
  input wire logic ref_b_differential,
  input wire logic ref_b_pos_pin_enable,
  input wire logic ref_b_neg_pin_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic xfer = wr_en && addr == ADDR_TRANSFER && wr_data[TRANSFER_BIT];
  property p_rdv; rd_en |=> rd_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("no read answer");
  property p_rdz; !$past(rd_en) |-> rd_data == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside read");
  // Reset edges excluded: outputs reload one edge late
  property p_hold; !$past(xfer, 2) && !$past(rst) && !$past(rst, 2)
    |-> $stable({ref_a_divide, ref_b_divide, feedback_divide, pump_current, auto_hold_enable,
    pump_tristate, pump_up_enable, pump_down_enable}); endproperty
  a_hold: assert property (p_hold) else $error("output moved without transfer");
  property p_div; ref_a_divide != 10'h000 && ref_b_divide != 10'h000 && feedback_divide != 10'h000; endproperty
  a_div: assert property (p_div) else $error("divide ratio zero");
  property p_tri; pump_tristate |-> !pump_up_enable && !pump_down_enable; endproperty
  a_tri: assert property (p_tri) else $error("pump drives in tristate");
  property p_drv; !pump_tristate |-> pump_up_enable || pump_down_enable; endproperty
  a_drv: assert property (p_drv) else $error("pump idle not tristate");
  property p_amode; ref_a_rx_enable |-> (ref_a_differential ?
    ref_a_pos_pin_enable && ref_a_neg_pin_enable : ref_a_pos_pin_enable != ref_a_neg_pin_enable); endproperty
  a_amode: assert property (p_amode) else $error("ref a pins wrong");
  property p_bmode; ref_b_rx_enable |-> (ref_b_differential ?
    ref_b_pos_pin_enable && ref_b_neg_pin_enable : ref_b_pos_pin_enable != ref_b_neg_pin_enable); endproperty
  a_bmode: assert property (p_bmode) else $error("ref b pins wrong");
  property p_aoff; !ref_a_rx_enable |-> !ref_a_pos_pin_enable && !ref_a_neg_pin_enable; endproperty
  a_aoff: assert property (p_aoff) else $error("ref a pins on while powered down");
  property p_boff; !ref_b_rx_enable |-> !ref_b_pos_pin_enable && !ref_b_neg_pin_enable; endproperty
  a_boff: assert property (p_boff) else $error("ref b pins on while powered down");
  c_xfer: cover property (xfer);
  c_up: cover property (pump_up_enable && !pump_down_enable);
  c_rd: cover property (rd_valid);
endmodule
bind rlc_regs rlc_regs_chk u_rlc_regs_chk (
  .clk(clk),
  .rst(rst),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .addr(addr),
  .wr_data(wr_data),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .ref_a_divide(ref_a_divide),
  .ref_b_divide(ref_b_divide),
  .feedback_divide(feedback_divide),
  .pump_current(pump_current),
  .pump_up_enable(pump_up_enable),
  .pump_down_enable(pump_down_enable),
  .pump_tristate(pump_tristate),
  .auto_hold_enable(auto_hold_enable),
  .ref_a_rx_enable(ref_a_rx_enable),
  .ref_a_differential(ref_a_differential),
  .ref_a_pos_pin_enable(ref_a_pos_pin_enable),
  .ref_a_neg_pin_enable(ref_a_neg_pin_enable),
  .ref_b_rx_enable(ref_b_rx_enable),
  .ref_b_differential(ref_b_differential),
  .ref_b_pos_pin_enable(ref_b_pos_pin_enable),
  .ref_b_neg_pin_enable(ref_b_neg_pin_enable)
);

// File: ref_loop_control_regs_tb_top.sv
// Testbench for the cleanup loop register bank.
// Drives the byte port directly; no serial front end.
`timescale 1ns/1ps
module ref_loop_control_regs_tb_top;
  import rlc_pkg::*;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic [15:0] addr = 0;
  logic [7:0] wr_data = 0, rd_data;
  logic [9:0] ref_a_divide, ref_b_divide, feedback_divide;
  logic [6:0] pump_current;
  logic rd_valid, pump_up_enable, pump_down_enable, pump_tristate, auto_hold_enable;
  logic ref_a_rx_enable, ref_a_differential, ref_a_pos_pin_enable, ref_a_neg_pin_enable;
  logic ref_b_rx_enable, ref_b_differential, ref_b_pos_pin_enable, ref_b_neg_pin_enable;
  int err_count = 0, tests_run = 0;
  // Reserved bits set on purpose; readback shows them dropped
  logic [7:0] wv [10] = '{8'hff, 8'hff, 8'h00, 8'h01, 8'h01, 8'h02, 8'ha5, 8'hff, 8'h58, 8'h01};
  logic [7:0] rv [10] = '{8'hff, 8'h03, 8'h00, 8'h01, 8'h01, 8'h02, 8'ha5, 8'h23, 8'h58, 8'h01};
  rlc_regs u_rlc_regs (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .ref_a_divide(ref_a_divide),
    .ref_b_divide(ref_b_divide),
    .feedback_divide(feedback_divide),
    .pump_current(pump_current),
    .pump_up_enable(pump_up_enable),
    .pump_down_enable(pump_down_enable),
    .pump_tristate(pump_tristate),
    .auto_hold_enable(auto_hold_enable),
    .ref_a_rx_enable(ref_a_rx_enable),
    .ref_a_differential(ref_a_differential),
    .ref_a_pos_pin_enable(ref_a_pos_pin_enable),
    .ref_a_neg_pin_enable(ref_a_neg_pin_enable),
    .ref_b_rx_enable(ref_b_rx_enable),
    .ref_b_differential(ref_b_differential),
    .ref_b_pos_pin_enable(ref_b_pos_pin_enable),
    .ref_b_neg_pin_enable(ref_b_neg_pin_enable)
  );
  always #2 clk = ~clk;
  task automatic chk(string n, logic [9:0] e, logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobe stays up between calls; idle drops it
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(negedge clk);
    rd_en = 0;
    wr_en = 1;
    addr = a;
    wr_data = d;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(negedge clk);
    wr_en = 0;
    rd_en = 1;
    addr = a;
    @(negedge clk);
    rd_en = 0;
    chk("rd_valid", 1, rd_valid);
    chk("rd_data", 10'(e), 10'(rd_data));
  endtask
  task automatic idle(int n);
    @(negedge clk);
    wr_en = 0;
    rd_en = 0;
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 0;
    chk("a_div", 10'h001, ref_a_divide);
    chk("tristate", 1, pump_tristate);
    chk("auto_hold", 1, auto_hold_enable);
    chk("rx_en", 0, {ref_a_rx_enable, ref_b_rx_enable});
    for (int i = 0; i < 10; i++) rd(ADDR_REF_A_DIV_LOW + 16'(i), 8'h00);
    for (int i = 0; i < 10; i++) wr(ADDR_REF_A_DIV_LOW + 16'(i), wv[i]);
    for (int i = 0; i < 10; i++) rd(ADDR_REF_A_DIV_LOW + 16'(i), rv[i]);
    rd(16'h010a, 8'h00);
    wr(ADDR_TRANSFER, 8'h00);
    idle(2);
    chk("a_div", 10'h001, ref_a_divide);
    wr(ADDR_TRANSFER, 8'h01);
    idle(2);
    chk("a_div", 10'h3ff, ref_a_divide);
    chk("b_div", 10'h100, ref_b_divide);
    chk("fb_div", 10'h201, feedback_divide);
    chk("current", 10'h025, 10'(pump_current));
    chk("tristate", 1, pump_tristate);
    chk("auto_hold", 0, auto_hold_enable);
    chk("b_pins", 10'h00f, {ref_b_rx_enable, ref_b_differential, ref_b_pos_pin_enable, ref_b_neg_pin_enable});
    chk("a_pins", 10'h009, {ref_a_rx_enable, ref_a_differential, ref_a_pos_pin_enable, ref_a_neg_pin_enable});
    wr(ADDR_REF_B_DIV_HIGH, 8'h00);
    wr(ADDR_PIN_SELECT, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PUMP_CURRENT, 8'h10);
      wr(ADDR_PUMP_MODE, 8'(m));
      wr(ADDR_TRANSFER, 8'h01);
      idle(2);
      chk("mode", 10'(m), {pump_up_enable, pump_down_enable});
      chk("tristate", 10'(m == 0), pump_tristate);
    end
    chk("b_div", 10'h001, ref_b_divide);
    chk("auto_hold", 1, auto_hold_enable);
    chk("a_pins", 10'h00a, {ref_a_rx_enable, ref_a_differential, ref_a_pos_pin_enable, ref_a_neg_pin_enable});
    chk("current", 10'h010, 10'(pump_current));
    wr(ADDR_RECEIVER, 8'h38);
    wr(ADDR_PIN_SELECT, 8'h02);
    wr(ADDR_TRANSFER, 8'h01);
    idle(2);
    chk("a_pins", 10'h00f, {ref_a_rx_enable, ref_a_differential, ref_a_pos_pin_enable, ref_a_neg_pin_enable});
    chk("b_pins", 10'h009, {ref_b_rx_enable, ref_b_differential, ref_b_pos_pin_enable, ref_b_neg_pin_enable});
    // Mid-run reset must restore defaults and clear the buffers
    @(negedge clk);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    chk("a_div", 10'h001, ref_a_divide);
    chk("rx_en", 0, {ref_a_rx_enable, ref_b_rx_enable});
    rd(ADDR_RECEIVER, 8'h00);
    conclude();
  end
endmodule
